//--- cbil_case_irq.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cbil_case_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cbil_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbil_pkg::DATA_W-1:0] pwdata,
  output logic [cbil_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic ext_irq_line_c,
  input wire logic ext_irq_line_d,
  input wire logic [7:0] user_test_inputs,
  input wire logic zero_flag,
  input wire logic overflow_flag,
  input wire logic sign_flag,
  input wire logic arith_carry_flag,
  input wire logic block_count_zero,
  input wire logic fifo_has_word,
  input wire logic fifo_entry_is_cmd,
  input wire logic fifo_type_mismatch,
  input wire logic addr_count_all_ones,
  input wire logic stack_full_flag,
  input wire logic fifo_not_full,
  input wire logic host_read_done_flag,
  input wire logic address_match_event,
  input wire logic instr_boundary,
  input wire logic [cbil_pkg::PC_W-1:0] pc,
  input wire logic case_op,
  input wire logic [1:0] case_group,
  input wire logic prio_case_op,
  input wire logic clear_irq_op,
  input wire logic [cbil_pkg::LVL_N-1:0] clear_sel,
  input wire logic [2:0] single_test_sel,
  output logic single_test_result,
  output logic branch_valid,
  output logic [cbil_pkg::PC_W-1:0] branch_addr,
  output logic vector_valid,
  output logic [cbil_pkg::PC_W-1:0] vector_addr,
  output logic push_valid,
  output logic [cbil_pkg::PC_W-1:0] push_data,
  output logic irq_pending_flag
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [cbil_pkg::EXT_N-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
  logic [7:0] user_s1_r, user_s2_r;
  logic [cbil_pkg::EXT_N-1:0] ext_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
      user_s1_r <= '0;
      user_s2_r <= '0;
    end else begin
      ext_s1_r <= {ext_irq_line_d, ext_irq_line_c, ext_irq_line_b, ext_irq_line_a};
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      user_s1_r <= user_test_inputs;
      user_s2_r <= user_s1_r;
    end
  end

  assign ext_edge = ext_s2_r & ~ext_s3_r;

  // ****************************************
  // register file
  // ****************************************
  logic [cbil_pkg::MASK_W-1:0] mask_r;
  logic mode_r;
  logic [cbil_pkg::STAT_W-1:0] stat_r, ien_r, stat_ev;
  logic [cbil_pkg::LVL_N-1:0] pend_r, unmasked, set_ev, clr_ev;
  logic wr_acc, setup, hit;
  logic [cbil_pkg::DATA_W-1:0] rd_nxt;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;

  always_comb begin
    hit = 1'b1;
    rd_nxt = '0;
    unique case (paddr)
      cbil_pkg::OFS_MASK: rd_nxt[cbil_pkg::MASK_W-1:0] = mask_r;
      cbil_pkg::OFS_MODE: rd_nxt[0] = mode_r;
      cbil_pkg::OFS_PEND: rd_nxt[cbil_pkg::PEND_FLAG_BIT:0] = {irq_pending_flag, pend_r};
      cbil_pkg::OFS_STAT: rd_nxt[cbil_pkg::STAT_W-1:0] = stat_r;
      cbil_pkg::OFS_IEN: rd_nxt[cbil_pkg::STAT_W-1:0] = ien_r;
      default: hit = 1'b0;
    endcase
  end

  // answer one cycle after setup, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd_nxt : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= cbil_pkg::MASK_RST;
      mode_r <= cbil_pkg::MODE_RST;
      ien_r <= cbil_pkg::IEN_RST;
    end else if (wr_acc) begin
      if (paddr == cbil_pkg::OFS_MASK) mask_r <= pwdata[cbil_pkg::MASK_W-1:0];
      if (paddr == cbil_pkg::OFS_MODE) mode_r <= pwdata[0];
      if (paddr == cbil_pkg::OFS_IEN) ien_r <= pwdata[cbil_pkg::STAT_W-1:0];
    end
  end

  // ****************************************
  // pending requests
  // ****************************************
  logic fault_cond, take;
  logic [2:0] top_lvl;

  function automatic logic [2:0] cbil_top(input logic [cbil_pkg::LVL_N-1:0] v);
    logic [2:0] t;
    t = '0;
    for (int i = 0; i < cbil_pkg::LVL_N; i++) begin
      if (v[i]) t = 3'(i);
    end
    return t;
  endfunction : cbil_top

  assign fault_cond = fifo_type_mismatch | addr_count_all_ones | stack_full_flag | ~fifo_not_full;
  assign unmasked = pend_r & ~mask_r[cbil_pkg::LVL_N-1:0];
  assign top_lvl = cbil_top(unmasked);
  assign take = instr_boundary & mode_r & (|unmasked);

  always_comb begin
    set_ev = '0;
    set_ev[cbil_pkg::EXT_N-1:0] = ext_edge;
    set_ev[cbil_pkg::LVL_SOFT] = 1'b1;
    set_ev[cbil_pkg::LVL_FIFO] = fifo_has_word;
    set_ev[cbil_pkg::LVL_DEBUG] = mask_r[cbil_pkg::MASK_SSTEP_BIT] ? instr_boundary
                                                                 : address_match_event;
    set_ev[cbil_pkg::LVL_FAULT] = fault_cond;
    clr_ev = clear_irq_op ? clear_sel : '0;
    if (take) clr_ev[top_lvl] = 1'b1;
  end

  // a new request in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_r <= '0;
    else pend_r <= (pend_r & ~clr_ev) | set_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_pending_flag <= 1'b0;
    else irq_pending_flag <= |unmasked;
  end

  // ****************************************
  // vector and return push
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_valid <= 1'b0;
      vector_addr <= '0;
      push_valid <= 1'b0;
      push_data <= '0;
    end else begin
      vector_valid <= take;
      push_valid <= take;
      if (take) begin
        vector_addr <= cbil_pkg::VEC_BASE + {7'h00, top_lvl};
        push_data <= pc + cbil_pkg::PC_STEP;
      end
    end
  end

  // ****************************************
  // case and priority case branching
  // ****************************************
  logic [3:0] case_pat, prio_ofs;
  logic prio_go;

  always_comb begin
    unique case (case_group)
      cbil_pkg::GRP_USER_LO: case_pat = user_s2_r[3:0];
      cbil_pkg::GRP_USER_HI: case_pat = user_s2_r[7:4];
      cbil_pkg::GRP_ALU: case_pat = {arith_carry_flag, sign_flag, overflow_flag, zero_flag};
      cbil_pkg::GRP_STATUS: case_pat = {fifo_entry_is_cmd, fifo_has_word, block_count_zero,
                                        irq_pending_flag};
    endcase
  end

  // priority case sees raw requests; mask gates vectored entry and the pending flag
  assign prio_go = prio_case_op & ~mode_r;
  assign prio_ofs = (|pend_r) ? {1'b0, cbil_pkg::PRIO_TOP_LVL - cbil_top(pend_r)}
                              : cbil_pkg::PRIO_NONE_OFS;

  // the offset is captured once, so later requests cannot redirect it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_valid <= 1'b0;
      branch_addr <= '0;
    end else begin
      branch_valid <= case_op | prio_go;
      if (case_op) branch_addr <= pc + cbil_pkg::PC_STEP + {6'h00, case_pat};
      else if (prio_go) branch_addr <= pc + cbil_pkg::PC_STEP + {6'h00, prio_ofs};
    end
  end

  // ****************************************
  // single condition test
  // ****************************************
  logic [7:0] single_vec;
  assign single_vec = {3'h0, host_read_done_flag, fifo_not_full, stack_full_flag,
                       addr_count_all_ones, fifo_type_mismatch};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) single_test_result <= 1'b0;
    else single_test_result <= single_vec[single_test_sel];
  end

  // ****************************************
  // software interrupt status
  // ****************************************
  always_comb begin
    stat_ev = '0;
    stat_ev[cbil_pkg::EXT_N-1:0] = ext_edge;
    stat_ev[cbil_pkg::STAT_VEC_BIT] = take;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_r <= cbil_pkg::STAT_RST;
    else if (wr_acc && paddr == cbil_pkg::OFS_STAT)
      stat_r <= (stat_r & ~pwdata[cbil_pkg::STAT_W-1:0]) | stat_ev;
    else stat_r <= stat_r | stat_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(stat_r & ien_r);
  end

  // ****************************************
  // checks
  // ****************************************
  property p_case_branch;
    @(posedge pclk) disable iff (!presetn)
      case_op |=> branch_valid && branch_addr == $past(pc) + cbil_pkg::PC_STEP + {6'h00, $past(case_pat)};
  endproperty
  a_case_branch: assert property (p_case_branch) else $error("case branch address wrong");

  property p_prio_blocked;
    @(posedge pclk) disable iff (!presetn)
      prio_case_op && mode_r && !case_op |=> !branch_valid;
  endproperty
  a_prio_blocked: assert property (p_prio_blocked) else $error("priority case ran in irq mode");

  // level 4 is always pending, so the empty case never occurs; check the top level instead
  property p_prio_top;
    @(posedge pclk) disable iff (!presetn)
      prio_go && !case_op && pend_r[cbil_pkg::LVL_FAULT] |=> branch_addr == $past(pc) + cbil_pkg::PC_STEP;
  endproperty
  a_prio_top: assert property (p_prio_top) else $error("priority case top target wrong");

  property p_ext_edge;
    @(posedge pclk) disable iff (!presetn)
      $rose(ext_s1_r[0]) |=> ##1 pend_r[0] || $past(clr_ev[0]);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("edge not pending in two cycles");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
      take |=> vector_valid && push_valid && vector_addr == cbil_pkg::VEC_BASE + {7'h00, $past(top_lvl)};
  endproperty
  a_vector: assert property (p_vector) else $error("vector address wrong");

  property p_no_take_masked;
    @(posedge pclk) disable iff (!presetn)
      instr_boundary && (unmasked == '0 || !mode_r) |=> !vector_valid;
  endproperty
  a_no_take_masked: assert property (p_no_take_masked) else $error("masked or idle vector taken");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
      fault_cond |=> pend_r[cbil_pkg::LVL_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault level not pending");

  property p_soft;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> pend_r[cbil_pkg::LVL_SOFT];
  endproperty
  a_soft: assert property (p_soft) else $error("soft level not pending");

  property p_cli;
    @(posedge pclk) disable iff (!presetn)
      clear_irq_op && clear_sel[0] && !set_ev[0] |=> !pend_r[0];
  endproperty
  a_cli: assert property (p_cli) else $error("clear op left level 0 pending");

  property p_push;
    @(posedge pclk) disable iff (!presetn)
      take |=> push_data == $past(pc) + cbil_pkg::PC_STEP;
  endproperty
  a_push: assert property (p_push) else $error("return push value wrong");

  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      (unmasked != '0) ##1 (unmasked != '0) |-> irq_pending_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("pending flag low with request");
endmodule : cbil_case_irq
`default_nettype wire

//--- cbil_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// far side: interrupt pins and user condition pins
// ****
module cbil_far_model (
  input wire logic pclk,
  output logic [3:0] irq_lines,
  output logic [7:0] user_pins
);
  initial irq_lines = 4'h0;
  initial user_pins = 8'h00;
  // held three cycles so the three-flop synchroniser cannot miss the edge
  task automatic rise(input int i);
    irq_lines[i] <= 1'b1;
    repeat (3) @(posedge pclk);
    irq_lines[i] <= 1'b0;
  endtask : rise
  task automatic set_user(input logic [7:0] v);
    user_pins <= v;
    repeat (3) @(posedge pclk);
  endtask : set_user
endmodule : cbil_far_model
`default_nettype wire

//--- cbil_pkg.sv
package cbil_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int PC_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_N = 8;
  localparam int EXT_N = 4;
  localparam int MASK_W = 9;
  localparam int STAT_W = 5;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PEND = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IEN = 8'h10;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int MASK_SSTEP_BIT = 8;
  localparam int PEND_FLAG_BIT = 8;
  localparam int STAT_VEC_BIT = 4;
  localparam logic [MASK_W-1:0] MASK_RST = 9'h1ff;
  localparam logic MODE_RST = 1'b0;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [STAT_W-1:0] IEN_RST = 5'h00;
  // ****************************************
  // interrupt levels and branch targets
  // ****************************************
  localparam int LVL_SOFT = 4;
  localparam int LVL_FIFO = 5;
  localparam int LVL_DEBUG = 6;
  localparam int LVL_FAULT = 7;
  localparam logic [PC_W-1:0] VEC_BASE = 10'h008;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  localparam logic [3:0] PRIO_NONE_OFS = 4'h8;
  localparam logic [2:0] PRIO_TOP_LVL = 3'h7;
  localparam logic [1:0] GRP_USER_LO = 2'h0;
  localparam logic [1:0] GRP_USER_HI = 2'h1;
  localparam logic [1:0] GRP_ALU = 2'h2;
  localparam logic [1:0] GRP_STATUS = 2'h3;
endpackage : cbil_pkg

//--- tb_case_branch_interrupt_logic.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_case_branch_interrupt_logic;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, user_test_inputs, clear_sel = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er, single_test_result, branch_valid, vector_valid, push_valid, irq_pending_flag;
  logic address_match_event = 1'b0, instr_boundary = 1'b0, case_op = 1'b0, prio_case_op = 1'b0, clear_irq_op = 1'b0;
  logic [1:0] case_group = 2'h0;
  logic [2:0] single_test_sel = 3'h0;
  logic [3:0] irq_lines;
  logic [11:0] fl = 12'h400;
  logic [cbil_pkg::PC_W-1:0] pc = 10'h120, branch_addr, vector_addr, push_data;
  int n_errors = 0, samples_checked = 0;
  always #12.5 pclk = ~pclk;
  cbil_far_model far_u (.pclk, .irq_lines, .user_pins(user_test_inputs));
  cbil_case_irq dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .ext_irq_line_a(irq_lines[0]), .ext_irq_line_b(irq_lines[1]), .ext_irq_line_c(irq_lines[2]),
    .ext_irq_line_d(irq_lines[3]), .user_test_inputs, .zero_flag(fl[0]), .overflow_flag(fl[1]),
    .sign_flag(fl[2]), .arith_carry_flag(fl[3]), .block_count_zero(fl[4]), .fifo_has_word(fl[5]),
    .fifo_entry_is_cmd(fl[6]), .fifo_type_mismatch(fl[7]), .addr_count_all_ones(fl[8]),
    .stack_full_flag(fl[9]), .fifo_not_full(fl[10]), .host_read_done_flag(fl[11]), .address_match_event,
    .instr_boundary, .pc, .case_op, .case_group, .prio_case_op, .clear_irq_op, .clear_sel, .single_test_sel,
    .single_test_result, .branch_valid, .branch_addr, .vector_valid, .vector_addr, .push_valid, .push_data,
    .irq_pending_flag
  );
  // ****
  // drivers
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic br(input logic p, input logic [1:0] g, input logic v, input logic [3:0] o);
    case_group <= g;
    case_op <= ~p;
    prio_case_op <= p;
    @(posedge pclk);
    case_op <= 1'b0;
    prio_case_op <= 1'b0;
    @(posedge pclk);
    `CHK("branch_valid", v, branch_valid)
    if (v) `CHK("branch_addr", pc + 10'h001 + {6'h00, o}, branch_addr)
  endtask : br
  task automatic take(input logic v, input logic [cbil_pkg::PC_W-1:0] a);
    instr_boundary <= 1'b1;
    @(posedge pclk);
    instr_boundary <= 1'b0;
    @(posedge pclk);
    `CHK("vector_valid", v, vector_valid)
    `CHK("push_valid", v, push_valid)
    if (v) `CHK("vector_addr", a, vector_addr)
    if (v) `CHK("push_data", pc + 10'h001, push_data)
  endtask : take
  task automatic clr(input logic [7:0] s);
    clear_sel <= s;
    clear_irq_op <= 1'b1;
    @(posedge pclk);
    clear_irq_op <= 1'b0;
    @(posedge pclk);
  endtask : clr
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    apb(1'b0, cbil_pkg::OFS_MASK, 32'h0);
    `CHK("mask reset", 32'h1ff, rd)
    apb(1'b0, cbil_pkg::OFS_MODE, 32'h0);
    `CHK("mode reset", 32'h0, rd)
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h0a5);
    apb(1'b0, cbil_pkg::OFS_MASK, 32'h0);
    `CHK("mask readback", 32'h0a5, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h1ff);
    $display("test regs done");
  endtask : t_regs
  task automatic t_case();
    far_u.set_user(8'ha5);
    fl[6:0] <= 7'b1011001;
    br(1'b0, 2'h0, 1'b1, 4'h5);
    br(1'b0, 2'h1, 1'b1, 4'ha);
    br(1'b0, 2'h2, 1'b1, 4'h9);
    br(1'b0, 2'h3, 1'b1, 4'ha);
    fl <= 12'h400;
    $display("test case done");
  endtask : t_case
  // selectors 0 to 4 are tried alone and then with every other flag raised; 5 to 7 with all flags raised
  task automatic t_single();
    for (int s = 0; s < 8; s++) begin
      single_test_sel <= 3'(s);
      fl <= (s < 5) ? 12'h080 << s : 12'hf80;
      repeat (2) @(posedge pclk);
      `CHK("single alone", 1'(s < 5), single_test_result)
      fl <= 12'hf80 ^ (12'h080 << s);
      repeat (2) @(posedge pclk);
      `CHK("single others", 1'b0, single_test_result)
    end
    fl <= 12'h400;
    $display("test single done");
  endtask : t_single
  task automatic t_prio();
    clr(8'hff);
    br(1'b1, 2'h0, 1'b1, 4'h3);
    fl[5] <= 1'b1;
    @(posedge pclk);
    br(1'b1, 2'h0, 1'b1, 4'h2);
    fl[7] <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("branch_addr held", pc + 10'h003, branch_addr)
    br(1'b1, 2'h0, 1'b1, 4'h0);
    apb(1'b1, cbil_pkg::OFS_MODE, 32'h1);
    br(1'b1, 2'h0, 1'b0, 4'h0);
    fl <= 12'h400;
    clr(8'hff);
    $display("test prio done");
  endtask : t_prio
  task automatic t_ext();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cbil_pkg::OFS_MASK, 32'h1ff ^ (32'h1 << i));
      far_u.rise(i);
      repeat (2) @(posedge pclk);
      `CHK("pending flag set", 1'b1, irq_pending_flag)
      pc <= 10'h200 + 10'(i);
      take(1'b1, cbil_pkg::VEC_BASE + 10'(i));
      @(posedge pclk);
      `CHK("pending flag clear", 1'b0, irq_pending_flag)
    end
    $display("test ext done");
  endtask : t_ext
  task automatic t_int();
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h00f);
    // single-step in the previous test left level 6 pending
    clr(8'hff);
    fl[9] <= 1'b1;
    fl[5] <= 1'b1;
    @(posedge pclk);
    fl[9] <= 1'b0;
    fl[5] <= 1'b0;
    take(1'b1, 10'h00f);
    take(1'b1, 10'h00d);
    take(1'b1, 10'h00c);
    address_match_event <= 1'b1;
    @(posedge pclk);
    address_match_event <= 1'b0;
    take(1'b1, 10'h00e);
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h1bf);
    take(1'b0, 10'h000);
    take(1'b1, 10'h00e);
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h1ff);
    take(1'b0, 10'h000);
    $display("test int done");
  endtask : t_int
  task automatic t_irq();
    apb(1'b1, cbil_pkg::OFS_STAT, 32'h1f);
    apb(1'b1, cbil_pkg::OFS_MASK, 32'h1ef);
    take(1'b1, 10'h00c);
    @(posedge pclk);
    `CHK("irq disabled", 1'b0, irq)
    apb(1'b1, cbil_pkg::OFS_IEN, 32'h10);
    @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, cbil_pkg::OFS_STAT, 32'h10);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test irq done");
  endtask : t_irq
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_case();
    t_single();
    t_prio();
    t_ext();
    t_int();
    t_irq();
    wrap_up();
  end
  // the tests need well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_case_branch_interrupt_logic
`default_nettype wire
